// ==== verilog/pps_pkg.sv ====
// Overview of operation
// - Power-on reset enters power-down without command
// - Power-down tri-states PCM and analog outputs
// - Low level or running clock powers up
// - PCM output waits for second frame sync
// - Static high on pin forces power-down
// - Short-frame sync mode selected at power-up
`default_nettype none
package pps_pkg;
	// Toggle timeout in ns; at 250 MHz one cycle is 4 ns
	localparam int CLK_PERIOD_NS = 4;
	localparam int PIN_TIMEOUT_NS = 2000;
	localparam int PIN_TIMEOUT_CYC = PIN_TIMEOUT_NS / CLK_PERIOD_NS;
	localparam int TMO_W = 10;
	localparam logic [1:0] FS_COUNT_ENABLE = 2'h2;

	typedef enum logic [2:0] {
		PPS_ST_DOWN = 3'h1,
		PPS_ST_ARMED = 3'h2,
		PPS_ST_ACTIVE = 3'h4
	} pps_state_t;

	// Output pin controls; enables are low while driving
	typedef struct packed {
		logic pcm_tx_oe_n;
		logic analog_rx_oe_n;
		logic circuits_on;
		logic long_frame_mode;
	} pps_ctrl_t;
endpackage
`default_nettype wire

// ==== verilog/pps_pin_detect.sv ====
`default_nettype none
module pps_pin_detect (
	clk_sys,
	nrst,
	clk_en,
	pin_level,
	pin_running,
	pin_static_high
);
	import pps_pkg::*;
	input wire logic clk_sys;
	input wire logic nrst;
	input wire logic clk_en;
	input wire logic pin_level;
	output logic pin_running;
	output logic pin_static_high;

	logic prev_r;
	logic [TMO_W-1:0] quiet_r;

	////////////////////////////////////////////////////////////////////////
	// Any edge restarts the quiet counter; running while below timeout
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			prev_r <= 1'b1;
			quiet_r <= TMO_W'(PIN_TIMEOUT_CYC);
		end else if (clk_en) begin
			prev_r <= pin_level;
			if (pin_level != prev_r) begin
				quiet_r <= '0;
			end else if (quiet_r < TMO_W'(PIN_TIMEOUT_CYC)) begin
				quiet_r <= quiet_r + 1'b1;
			end
		end
	end

	// Reset starts at timeout so a static pin decides at once
	assign pin_running = (quiet_r < TMO_W'(PIN_TIMEOUT_CYC));
	assign pin_static_high = !pin_running && prev_r;
endmodule
`default_nettype wire

// ==== verilog/pps_sequencer.sv ====
`default_nettype none
module pps_sequencer (
	clk_sys,
	nrst,
	clk_en,
	rx_master_clock_powerdown_pin,
	tx_frame_sync,
	long_frame_detected,
	ctrl,
	powered_up
);
	import pps_pkg::*;
	input wire logic clk_sys;
	input wire logic nrst;
	input wire logic clk_en;
	input wire logic rx_master_clock_powerdown_pin;
	input wire logic tx_frame_sync;
	input wire logic long_frame_detected;
	output pps_pkg::pps_ctrl_t ctrl;
	output logic powered_up;

	pps_state_t state_r;
	pps_state_t state_nxt;
	logic [1:0] fs_cnt_r;
	logic fs_prev_r;
	logic fs_rise;
	logic pin_running;
	logic pin_static_high;
	logic want_down;

	////////////////////////////////////////////////////////////////////////
	pps_pin_detect u_detect (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.clk_en(clk_en),
		.pin_level(rx_master_clock_powerdown_pin),
		.pin_running(pin_running),
		.pin_static_high(pin_static_high)
	);

	// A running clock never counts as static high, so it powers up
	assign want_down = pin_static_high;
	assign fs_rise = tx_frame_sync && !fs_prev_r;

	////////////////////////////////////////////////////////////////////////
	// State decisions
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			PPS_ST_DOWN: begin
				if (!want_down) begin
					state_nxt = PPS_ST_ARMED;
				end
			end
			PPS_ST_ARMED: begin
				if (want_down) begin
					state_nxt = PPS_ST_DOWN;
				end else if (fs_rise && fs_cnt_r == FS_COUNT_ENABLE - 2'h1) begin
					state_nxt = PPS_ST_ACTIVE;
				end
			end
			PPS_ST_ACTIVE: begin
				if (want_down) begin
					state_nxt = PPS_ST_DOWN;
				end
			end
			default: begin
				state_nxt = PPS_ST_DOWN;
			end
		endcase
	end

	// Power-on reset lands in power-down with no command needed
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			state_r <= PPS_ST_DOWN;
		end else if (clk_en) begin
			state_r <= state_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Frame sync edge counter, cleared whenever powered down
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			fs_prev_r <= 1'b0;
			fs_cnt_r <= 2'h0;
		end else if (clk_en) begin
			fs_prev_r <= tx_frame_sync;
			if (state_r != PPS_ST_ARMED) begin
				fs_cnt_r <= 2'h0;
			end else if (fs_rise) begin
				fs_cnt_r <= fs_cnt_r + 2'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registered pin controls; analog output follows power, PCM waits
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			ctrl.pcm_tx_oe_n <= 1'b1;
			ctrl.analog_rx_oe_n <= 1'b1;
			ctrl.circuits_on <= 1'b0;
			ctrl.long_frame_mode <= 1'b0;
			powered_up <= 1'b0;
		end else if (clk_en) begin
			ctrl.pcm_tx_oe_n <= (state_nxt != PPS_ST_ACTIVE);
			ctrl.analog_rx_oe_n <= (state_nxt == PPS_ST_DOWN);
			ctrl.circuits_on <= (state_nxt != PPS_ST_DOWN);
			powered_up <= (state_nxt != PPS_ST_DOWN);
			// Short-frame on every power-up until a long pulse is seen
			if (state_nxt == PPS_ST_DOWN) begin
				ctrl.long_frame_mode <= 1'b0;
			end else if (long_frame_detected) begin
				ctrl.long_frame_mode <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== tb/pps_ctl.sv ====
`default_nettype none
module pps_ctl (
	input wire logic clk_sys,
	input wire logic [1:0] mode,
	input wire logic fs_on,
	output logic pin = 1'b1,
	output logic fs = 1'b0
);
	timeunit 1ns / 1ps;
	logic [3:0] ph = 4'h0;
	// Mode 0 forces power-down, 1 runs a clock, 2 holds low; syncs only once told
	always @(posedge clk_sys) begin
		ph <= #1 ph + 4'h1;
		pin <= #1 !mode[1] && (!mode[0] || ph[1]);
		fs <= #1 fs_on && &ph;
	end
endmodule
`default_nettype wire

// ==== tb/pps_sva.sv ====
`default_nettype none
module pps_sva (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic rx_master_clock_powerdown_pin,
	input wire pps_pkg::pps_ctrl_t ctrl,
	input wire logic powered_up
);
	logic [9:0] hi_r;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// Run length of a high pin, saturating so it never wraps back
	always_ff @(posedge clk_sys) begin
		hi_r <= !nrst || !rx_master_clock_powerdown_pin ? 10'h0 : hi_r + 10'(hi_r != 10'h3FF);
	end
	// Power comes up on the first clock edge after the one that first samples the pin leaving static high
	sequence s_power_rise;
		$rose(powered_up);
	endsequence
	a_por_down: assert property (disable iff (1'b0) !nrst |=> !powered_up && ctrl.pcm_tx_oe_n) else $error("up");
	a_low_up: assert property (!rx_master_clock_powerdown_pin [*3] |=> powered_up) else $error("no up");
	a_high_down: assert property (hi_r == 10'h1F9 |-> !powered_up) else $error("no down");
	a_run_up: assert property ($past(powered_up) && hi_r < 10'h190 |-> powered_up) else $error("drop");
	a_down_quiet: assert property (!powered_up |-> ctrl.analog_rx_oe_n && ctrl.pcm_tx_oe_n) else $error("driven");
	a_pcm_waits: assert property (s_power_rise |-> ctrl.pcm_tx_oe_n) else $error("pcm early");
	a_short_start: assert property (s_power_rise |-> $past(!ctrl.long_frame_mode)) else $error("long");
endmodule
bind pps_sequencer pps_sva i_pps_sva (.clk_sys(clk_sys), .nrst(nrst), .ctrl(ctrl), .powered_up(powered_up),
	.rx_master_clock_powerdown_pin(rx_master_clock_powerdown_pin));
`default_nettype wire

// ==== tb/pps_sequencer_tb_top.sv ====
`default_nettype none
module pps_sequencer_tb_top;
	timeunit 1ns / 1ps;
	import pps_pkg::*;
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; $display("unexpected %0t value", $time); end end
	logic clk_sys = 1'b0, nrst = 1'b0, fs_on = 1'b0, lfd = 1'b0;
	logic [1:0] mode = 2'h0;
	logic pin, fs, up;
	pps_ctrl_t ctrl;
	int errors = 0, cmp_count = 0, n, p;
	logic [2:0] rows [4] = '{3'h5, 3'h0, 3'h3, 3'h0};
	always #2 clk_sys = ~clk_sys;
	pps_ctl i_pps_ctl (.clk_sys(clk_sys), .mode(mode), .fs_on(fs_on), .pin(pin), .fs(fs));
	pps_sequencer i_pps_sequencer (.clk_sys(clk_sys), .nrst(nrst), .clk_en(1'b1), .rx_master_clock_powerdown_pin(pin),
		.tx_frame_sync(fs), .long_frame_detected(lfd), .ctrl(ctrl), .powered_up(up));
	task automatic step(input int c);
		repeat (c) @(posedge clk_sys);
		#1;
	endtask
	task automatic results;
		$display("counts %0d %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Pin mode table, then syncs refused while down and counted once up
	initial begin
		step(12);
		`CHK(ctrl, 4'hC)
		nrst = 1'b1;
		foreach (rows[i]) begin
			mode = rows[i][2:1];
			step(520);
			`CHK({up, ctrl.analog_rx_oe_n}, {rows[i][0], !rows[i][0]})
			$display("row %0d done", i);
		end
		fs_on = 1'b1;
		step(40);
		fs_on = 1'b0;
		mode = 2'h2;
		step(9);
		fs_on = 1'b1;
		p = 0;
		for (n = 0; n < 99 && ctrl.pcm_tx_oe_n !== 1'b0; n++) begin
			@(posedge clk_sys);
			p += int'(fs);
			#1;
		end
		if (n == 99) begin
			errors++;
			$display("unexpected %0t sync timeout", $time);
		end
		`CHK(p, 2)
		`CHK(ctrl.long_frame_mode, 1'b0)
		lfd = 1'b1;
		step(2);
		`CHK(ctrl.long_frame_mode, 1'b1)
		$display("sync done");
		nrst = 1'b0;
		step(1);
		`CHK(ctrl, 4'hC)
		$display("reset done");
		results();
	end
endmodule
`default_nettype wire
